// ==== logic/clock_ratio_pkg.sv ====
/*
 * shared constants of the clock ratio control block: register offsets,
 * field positions, reset images, code sets, status layout, strap timing.
 * assumes: imported whole by every module of the block.
 */
package clock_ratio_pkg;

    // register map, byte addresses on the plain register port
    localparam int          ADDR_W            = 8;
    localparam logic [7:0]  RATIO_REG_OFFSET  = 8'h00;
    localparam logic [7:0]  STATUS_REG_OFFSET = 8'h04;

    // field positions inside the ratio register
    localparam int VCO_LSB  = 30;
    localparam int MULT_LSB = 24;
    localparam int CPU_LSB  = 20;
    localparam int SYS_LSB  = 12;
    localparam int EXT_LSB  = 8;
    localparam int PER_LSB  = 0;

    // power-on images chosen by the mode pins, and the software-writable bits
    localparam logic [31:0] RATIO_IMAGE_PLL   = 32'h0755_5558;
    localparam logic [31:0] RATIO_IMAGE_NOPLL = 32'h0700_0000;
    localparam logic [31:0] WRITABLE_MASK     = 32'hDFF0_FF0F;

    // mode pin pairs, written {high pin, low pin}
    localparam logic [1:0] MODE_PLL_EXT  = 2'h0;
    localparam logic [1:0] MODE_NO_PLL   = 2'h1;
    localparam logic [1:0] MODE_PLL_XTAL = 2'h2;
    localparam logic [1:0] MODE_BAD      = 2'h3;

    // vco range codes
    localparam logic [1:0] VCO_HIGH = 2'h0;
    localparam logic [1:0] VCO_LOW  = 2'h3;

    // legal multiplication codes (ratio is code plus one)
    localparam logic [4:0] MULT_X2  = 5'h01;
    localparam logic [4:0] MULT_X3  = 5'h02;
    localparam logic [4:0] MULT_X4  = 5'h03;
    localparam logic [4:0] MULT_X6  = 5'h05;
    localparam logic [4:0] MULT_X8  = 5'h07;
    localparam logic [4:0] MULT_X16 = 5'h0F;

    // divider codes shared by all four dividers
    localparam logic [3:0] DIV_1  = 4'h0;
    localparam logic [3:0] DIV_2  = 4'h2;
    localparam logic [3:0] DIV_3  = 4'h4;
    localparam logic [3:0] DIV_4  = 4'h5;
    localparam logic [3:0] DIV_6  = 4'h7;
    localparam logic [3:0] DIV_8  = 4'h8;
    localparam logic [3:0] DIV_10 = 4'h9;
    localparam logic [3:0] DIV_12 = 4'hA;
    localparam logic [3:0] DIV_16 = 4'hB;
    localparam logic [3:0] DIV_20 = 4'hC;

    // output values that match the mode 0 image while the strap settles
    localparam logic [5:0] MULT_OUT_RESET = 6'h08;
    localparam logic [4:0] CPU_OUT_RESET  = 5'h04;
    localparam logic [4:0] BUS_OUT_RESET  = 5'h04;
    localparam logic [4:0] PER_OUT_RESET  = 5'h08;

    // status register bit positions
    localparam int ST_STRAP_DONE = 0;
    localparam int ST_MODE_BAD   = 1;
    localparam int ST_VCO_BAD    = 2;
    localparam int ST_MULT_BAD   = 3;
    localparam int ST_DIV_BAD    = 4;
    localparam int ST_MODE_PINS  = 8;

    // cycles after reset before the synchronised mode pins are trusted
    localparam int STRAP_SETTLE_CYCLES = 4;

    typedef enum logic [1:0] {STRAP_SETTLE, STRAP_LOAD, STRAP_RUN} strap_state_t;

endpackage : clock_ratio_pkg

// ==== logic/divider_code_if.sv ====
/*
 * carrier between the ratio register and a divider code decoder.
 * assumes: one instance per divider, both ends on sys_clk logic.
 */
`timescale 1ns/1ps
interface divider_code_if;
    logic [3:0] code;
    logic       allowThird;
    logic [4:0] ratio;
    logic       legal;

    modport requester (output code, output allowThird, input ratio, input legal);
    modport decoder   (input code, input allowThird, output ratio, output legal);
endinterface : divider_code_if

// ==== logic/mode_pin_sync.sv ====
/*
 * three-stage synchroniser for one mode pin with agreement filter.
 * assumes: pin is asynchronous to sys_clk; sys_rst synchronous, high.
 */
`timescale 1ns/1ps
module mode_pin_sync
    import clock_ratio_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic pinIn,
    output logic      level,
    output logic      stable
);
    logic meta;
    logic syncA;
    logic syncB;

    // first stage feeds only the second; a change counts once the second and third agree
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta  <= 1'b0;
            syncA <= 1'b0;
            syncB <= 1'b0;
            level <= 1'b0;
        end else begin
            meta  <= pinIn;
            syncA <= meta;
            syncB <= syncA;
            if (syncA == syncB) begin
                level <= syncB;
            end
        end
    end

    assign stable = (syncA == syncB);
endmodule : mode_pin_sync

// ==== logic/divider_code_decode.sv ====
/*
 * decodes one four-bit divider code into its division denominator.
 * assumes: driven through divider_code_if; purely combinational.
 */
`timescale 1ns/1ps
module divider_code_decode
    import clock_ratio_pkg::*;
(
    divider_code_if.decoder port
);
    // returns {legal, denominator}; the third is refused where not offered
    function automatic logic [5:0] divider_ratio(input logic [3:0] code,
                                                  input logic       third);
        logic [5:0] result;
        result = 6'h00;
        case (code)
            DIV_1:   result = 6'h21;
            DIV_2:   result = 6'h22;
            DIV_3:   result = third ? 6'h23 : 6'h00;
            DIV_4:   result = 6'h24;
            DIV_6:   result = 6'h26;
            DIV_8:   result = 6'h28;
            DIV_10:  result = 6'h2A;
            DIV_12:  result = 6'h2C;
            DIV_16:  result = 6'h30;
            DIV_20:  result = 6'h34;
            default: result = 6'h00;
        endcase
        return result;
    endfunction : divider_ratio

    logic [5:0] decoded;

    // split the packed answer onto the carrier
    always_comb begin
        decoded    = divider_ratio(port.code, port.allowThird);
        port.legal = decoded[5];
        port.ratio = decoded[4:0];
    end
endmodule : divider_code_decode

// ==== logic/clock_ratio_control.sv ====
/*
 * frequency ratio control register of the clock generator: vco range,
 * pll multiplication and four divider ratios, loaded from the mode pins
 * after power-on reset and then owned by software.
 * assumes: sys_rst is the power-on reset; mode pins are static straps
 * asynchronous to sys_clk; the clock datapath consumes the ratio outputs.
 */
`timescale 1ns/1ps
module clock_ratio_control
    import clock_ratio_pkg::*;
#(
    parameter int SETTLE_CYCLES = STRAP_SETTLE_CYCLES
)
(
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [31:0]       regWrData,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    output logic      [31:0]       regRdData,
    input  wire logic              clock_mode_pin_low,
    input  wire logic              clock_mode_pin_high,
    output logic                   vcoLowSpeed,
    output logic      [5:0]        pllMultiply,
    output logic      [4:0]        cpuDivide,
    output logic      [4:0]        systemBusDivide,
    output logic      [4:0]        externalBusDivide,
    output logic      [4:0]        peripheralDivide,
    output logic                   ratioReady
);

    ////////////////////////////////////////////////////////////////////////
    // elaboration checks

    // the strap must not be sampled before the synchronisers have filled
    if (SETTLE_CYCLES < 3 || SETTLE_CYCLES > 255) begin : g_bad_settle
        $error("SETTLE_CYCLES must lie between 3 and 255");
    end

    ////////////////////////////////////////////////////////////////////////
    // mode pin synchronisers

    logic modeLowLevel;
    logic modeLowStable;
    logic modeHighLevel;
    logic modeHighStable;

    mode_pin_sync u_sync_low (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .pinIn   (clock_mode_pin_low),
        .level   (modeLowLevel),
        .stable  (modeLowStable)
    );

    mode_pin_sync u_sync_high (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .pinIn   (clock_mode_pin_high),
        .level   (modeHighLevel),
        .stable  (modeHighStable)
    );

    ////////////////////////////////////////////////////////////////////////
    // strap sequencer

    strap_state_t strapState;
    logic [7:0]   settleCount;
    logic [1:0]   modePins;
    logic [1:0]   strappedPins;
    logic         strapDone;
    logic         loadStrap;
    logic [31:0]  strapImage;

    assign modePins  = {modeHighLevel, modeLowLevel};
    assign loadStrap = (strapState == STRAP_LOAD);
    assign strapDone = (strapState == STRAP_RUN);

    // wait for the synchronisers, load once the pins agree, then hand over
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            strapState  <= STRAP_SETTLE;
            settleCount <= 8'h00;
        end else begin
            case (strapState)
                STRAP_SETTLE: begin
                    if (settleCount == 8'(SETTLE_CYCLES - 1)) begin
                        if (modeLowStable && modeHighStable) begin
                            strapState <= STRAP_LOAD;
                        end
                    end else begin
                        settleCount <= settleCount + 8'h01;
                    end
                end
                STRAP_LOAD: begin
                    strapState <= STRAP_RUN;
                end
                STRAP_RUN: begin
                    strapState <= STRAP_RUN;
                end
                default: begin
                    strapState <= STRAP_SETTLE;
                end
            endcase
        end
    end

    // mode pins pick the image
    // a prohibited pair falls back to the pll image so the clocks still run
    always_comb begin
        case (modePins)
            MODE_PLL_EXT:  strapImage = RATIO_IMAGE_PLL;
            MODE_NO_PLL:   strapImage = RATIO_IMAGE_NOPLL;
            MODE_PLL_XTAL: strapImage = RATIO_IMAGE_PLL;
            default:       strapImage = RATIO_IMAGE_PLL;
        endcase
    end

    // remember which mode was strapped, for software to inspect
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            strappedPins <= MODE_PLL_EXT;
        end else if (loadStrap) begin
            strappedPins <= modePins;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ratio register

    logic [31:0] ratioReg;
    logic        ratioWriteHit;

    // writes before the strap is loaded are dropped so the strap cannot be lost
    assign ratioWriteHit = regWrite && strapDone && (regAddr == RATIO_REG_OFFSET);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ratioReg <= RATIO_IMAGE_PLL;
        end else if (loadStrap) begin
            ratioReg <= strapImage;
        end else if (ratioWriteHit) begin
            ratioReg <= (regWrData & WRITABLE_MASK) | (ratioReg & ~WRITABLE_MASK);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // field decoding

    logic [1:0] vcoCode;
    logic [4:0] multCode;
    logic       vcoLegal;
    logic       multLegal;
    logic [3:0] dividerCode [4];
    logic [3:0] dividerBad;

    assign vcoCode        = ratioReg[VCO_LSB +: 2];
    assign multCode       = ratioReg[MULT_LSB +: 5];
    assign dividerCode[0] = ratioReg[CPU_LSB +: 4];
    assign dividerCode[1] = ratioReg[SYS_LSB +: 4];
    assign dividerCode[2] = ratioReg[EXT_LSB +: 4];
    assign dividerCode[3] = ratioReg[PER_LSB +: 4];

    // only 00 and 11 are vco ranges
    assign vcoLegal = (vcoCode == VCO_HIGH) || (vcoCode == VCO_LOW);

    // only ratios the pll is built for are accepted
    always_comb begin
        case (multCode)
            MULT_X2, MULT_X3, MULT_X4,
            MULT_X6, MULT_X8, MULT_X16: multLegal = 1'b1;
            default:                    multLegal = 1'b0;
        endcase
    end

    divider_code_if dividerIf [4] ();

    for (genvar i = 0; i < 4; i++) begin : g_divider
        assign dividerIf[i].code       = dividerCode[i];
        assign dividerIf[i].allowThird = (i != 0);
        assign dividerBad[i]           = ~dividerIf[i].legal;

        divider_code_decode u_decode (
            .port (dividerIf[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // ratio outputs to the clock datapath

    // a prohibited code leaves its output at the last legal setting,
    // so a bad write can never hand the datapath a ratio it cannot make
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            vcoLowSpeed <= 1'b0;
        end else if (vcoLegal) begin
            vcoLowSpeed <= (vcoCode == VCO_LOW);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pllMultiply <= MULT_OUT_RESET;
        end else if (multLegal) begin
            pllMultiply <= {1'b0, multCode} + 6'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cpuDivide <= CPU_OUT_RESET;
        end else if (dividerIf[0].legal) begin
            cpuDivide <= dividerIf[0].ratio;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            systemBusDivide   <= BUS_OUT_RESET;
            externalBusDivide <= BUS_OUT_RESET;
        end else begin
            if (dividerIf[1].legal) begin
                systemBusDivide <= dividerIf[1].ratio;
            end
            if (dividerIf[2].legal) begin
                externalBusDivide <= dividerIf[2].ratio;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            peripheralDivide <= PER_OUT_RESET;
        end else if (dividerIf[3].legal) begin
            peripheralDivide <= dividerIf[3].ratio;
        end
    end

    // outputs follow the register one cycle late; ready once the strap is in
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ratioReady <= 1'b0;
        end else begin
            ratioReady <= strapDone;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status and read port

    logic [31:0] statusWord;

    // live view of strap progress and of any prohibited code now held
    always_comb begin
        statusWord                       = 32'h0000_0000;
        statusWord[ST_STRAP_DONE]        = strapDone;
        statusWord[ST_MODE_BAD]          = strapDone && (strappedPins == MODE_BAD);
        statusWord[ST_VCO_BAD]           = ~vcoLegal;
        statusWord[ST_MULT_BAD]          = ~multLegal;
        statusWord[ST_DIV_BAD +: 4]      = dividerBad;
        statusWord[ST_MODE_PINS +: 2]    = strappedPins;
    end

    // whole-word read, one cycle later
    // unmapped addresses and idle cycles read as zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            regRdData <= 32'h0000_0000;
        end else if (regRead) begin
            case (regAddr)
                RATIO_REG_OFFSET:  regRdData <= ratioReg;
                STATUS_REG_OFFSET: regRdData <= statusWord;
                default:           regRdData <= 32'h0000_0000;
            endcase
        end else begin
            regRdData <= 32'h0000_0000;
        end
    end

endmodule : clock_ratio_control

// ==== sim/clock_ratio_checker.sv ====
/*
 * concurrent checks on the ports of the clock ratio control block.
 * assumes: one sys_clk domain, sys_rst synchronous and active high.
 */
`timescale 1ns/1ps
module clock_ratio_checker
    import clock_ratio_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              sys_rst,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [31:0]       regWrData,
    input wire logic              regWrite,
    input wire logic              regRead,
    input wire logic [31:0]       regRdData,
    input wire logic              clock_mode_pin_low,
    input wire logic              clock_mode_pin_high,
    input wire logic              vcoLowSpeed,
    input wire logic [5:0]        pllMultiply,
    input wire logic [4:0]        cpuDivide,
    input wire logic [4:0]        systemBusDivide,
    input wire logic [4:0]        externalBusDivide,
    input wire logic [4:0]        peripheralDivide,
    input wire logic              ratioReady
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    logic        wr0;  // write that the register really takes
    logic        multOk;
    logic [31:0] d1;
    logic [31:0] d2;

    // outputs answer two edges late, so keep the written word that long
    assign wr0    = regWrite && regAddr == RATIO_REG_OFFSET && ratioReady;
    assign multOk = regWrData[28:24] inside {MULT_X2, MULT_X3, MULT_X4, MULT_X6, MULT_X8, MULT_X16};
    always_ff @(posedge sys_clk) begin
        d1 <= regWrData;
        d2 <= d1;
    end

    function automatic logic [4:0] den(input logic [3:0] c);
        case (c)
            DIV_1:   return 5'h01;
            DIV_2:   return 5'h02;
            DIV_3:   return 5'h03;
            DIV_4:   return 5'h04;
            DIV_6:   return 5'h06;
            DIV_8:   return 5'h08;
            DIV_10:  return 5'h0A;
            DIV_12:  return 5'h0C;
            DIV_16:  return 5'h10;
            DIV_20:  return 5'h14;
            default: return 5'h00;
        endcase
    endfunction : den

    ////////////////////////////////////////////////////////////////////////////////
    a_read_idle: assert property (!$past(regRead) |-> regRdData == 32'h0)
        else $error("read data outside its slot");
    a_ready_holds: assert property ($past(ratioReady) |-> ratioReady)
        else $error("ready dropped");
    a_vco_low: assert property (wr0 && regWrData[31:30] == VCO_LOW |-> ##2 vcoLowSpeed)
        else $error("vco low not applied");
    a_vco_high: assert property (wr0 && regWrData[31:30] == VCO_HIGH |-> ##2 !vcoLowSpeed)
        else $error("vco high not applied");
    a_vco_hold: assert property (wr0 && regWrData[31] != regWrData[30]
        |-> ##2 $stable(vcoLowSpeed))
        else $error("prohibited vco code applied");
    a_mult_ratio: assert property (wr0 && multOk
        |-> ##2 pllMultiply == {1'b0, d2[28:24]} + 6'h01)
        else $error("multiplier wrong");
    a_mult_hold: assert property (wr0 && !multOk |-> ##2 $stable(pllMultiply))
        else $error("prohibited multiplier applied");
    a_cpu_ratio: assert property (wr0 && den(regWrData[23:20]) != 5'h00
        && regWrData[23:20] != DIV_3 |-> ##2 cpuDivide == den(d2[23:20]))
        else $error("cpu divider wrong");
    a_cpu_third: assert property (wr0 && regWrData[23:20] == DIV_3
        |-> ##2 $stable(cpuDivide))
        else $error("cpu took third");
    a_bus_ratio: assert property (wr0 && den(regWrData[15:12]) != 5'h00
        && den(regWrData[11:8]) != 5'h00 |-> ##2 systemBusDivide == den(d2[15:12])
        && externalBusDivide == den(d2[11:8]))
        else $error("bus divider wrong");
    a_per_ratio: assert property (wr0 && den(regWrData[3:0]) != 5'h00
        |-> ##2 peripheralDivide == den(d2[3:0]))
        else $error("peripheral divider wrong");
endmodule : clock_ratio_checker

bind clock_ratio_control clock_ratio_checker chk_u (
    .sys_clk, .sys_rst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .clock_mode_pin_low, .clock_mode_pin_high, .vcoLowSpeed, .pllMultiply, .cpuDivide,
    .systemBusDivide, .externalBusDivide, .peripheralDivide, .ratioReady
);

// ==== sim/clock_ratio_control_test.sv ====
/*
 * self-checking bench of the clock ratio control block: strap modes,
 * whole-word writes and reads, prohibited codes, reserved bits.
 * assumes: package, design and checker compiled before it.
 */
`timescale 1ns/1ps
module clock_ratio_control_test
    import clock_ratio_pkg::*;
;
    logic              sys_clk, sys_rst, regWrite, regRead, pinLow, pinHigh;
    logic [ADDR_W-1:0] regAddr;
    logic [31:0]       regWrData, regRdData, d, d2, expReg;
    logic              vcoLowSpeed, ratioReady, expVco;
    logic [5:0]        pllMultiply, expMult;
    logic [4:0]        cpuDivide, systemBusDivide, externalBusDivide, peripheralDivide;
    logic [4:0]        expCpu, expSys, expExt, expPer;
    int                nMismatch, testsRun, cycles;
    logic [3:0] divCode [10] = '{DIV_1, DIV_2, DIV_3, DIV_4, DIV_6, DIV_8, DIV_10, DIV_12,
                                 DIV_16, DIV_20};
    logic [4:0] divDen  [10] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0A, 5'h0C,
                                 5'h10, 5'h14};
    logic [4:0] multCode [6] = '{MULT_X2, MULT_X3, MULT_X4, MULT_X6, MULT_X8, MULT_X16};
    logic [5:0] multRes  [6] = '{6'h02, 6'h03, 6'h04, 6'h06, 6'h08, 6'h10};
    // rows of divCode indices {cpu, sys, ext, per}, each divides the next
    logic [15:0] divChain [17] = '{16'h0000, 16'h0135, 16'h0247, 16'h1358, 16'h0169,
                                   16'h3339, 16'h4477, 16'h5588, 16'h6699, 16'h7777,
                                   16'h8888, 16'h9999, 16'h0222, 16'h1111, 16'h0014,
                                   16'h0113, 16'h0016};

    clock_ratio_control dut_u (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .clock_mode_pin_low(pinLow), .clock_mode_pin_high(pinHigh),
        .vcoLowSpeed(vcoLowSpeed), .pllMultiply(pllMultiply), .cpuDivide(cpuDivide),
        .systemBusDivide(systemBusDivide), .externalBusDivide(externalBusDivide),
        .peripheralDivide(peripheralDivide), .ratioReady(ratioReady)
    );

    // 200 MHz clock, and a ceiling on run length in case of a hang
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            nMismatch++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            nMismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // strobes drop at the edge and may rise again 1 ns later: back to back
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        regAddr   <= a;
        regWrData <= v;
        regWrite  <= 1'b1;
        @(posedge sys_clk);
        regWrite  <= 1'b0;
        #1;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1 v = regRdData;
    endtask : rd

    task automatic checkOutputs();
        check("vco", vcoLowSpeed, expVco);
        check("mult", pllMultiply, expMult);
        check("cpu", cpuDivide, expCpu);
        check("sysbus", systemBusDivide, expSys);
        check("extbus", externalBusDivide, expExt);
        check("periph", peripheralDivide, expPer);
    endtask : checkOutputs

    // a write right after release must be dropped; the strap image wins
    task automatic doReset(input logic [1:0] pins);
        {pinHigh, pinLow} <= pins;
        sys_rst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1;
        wr(RATIO_REG_OFFSET, 32'h0000_0000);
        for (int i = 0; i < 40 && ratioReady !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        check("ready", ratioReady, 1'b1);
        expReg  = (pins == MODE_NO_PLL) ? RATIO_IMAGE_NOPLL : RATIO_IMAGE_PLL;
        expVco  = 1'b0;
        expMult = 6'h08;
        {expCpu, expSys, expExt, expPer} = (pins == MODE_NO_PLL) ? {4{5'h01}}
                                         : {5'h04, 5'h04, 5'h04, 5'h08};
    endtask : doReset

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", testsRun, nMismatch);
        if (nMismatch == 0 && testsRun > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 0; sys_rst = 1; regAddr = 0; regWrData = 0; regWrite = 0; regRead = 0;
        pinLow = 0; pinHigh = 0; nMismatch = 0; testsRun = 0; cycles = 0;
        // every strap mode; pins moved later must not matter
        for (int m = 3; m >= 0; m--) begin
            doReset(m[1:0]);
            rd(RATIO_REG_OFFSET, d);
            check("image", d, expReg);
            rd(STATUS_REG_OFFSET, d);
            check("status", d[9:0], {m[1:0], 6'h00, m == 3, 1'b1});
            checkOutputs();
            {pinHigh, pinLow} <= ~m[1:0];
            // long enough for the new pins to clear the synchronisers
            repeat (6) @(posedge sys_clk);
            rd(RATIO_REG_OFFSET, d);
            check("image kept", d, expReg);
        end
        // every legal code in whole-multiple chains, reserved bits written as ones
        for (int i = 0; i < 17; i++) begin
            d = {i[0] ? VCO_LOW : VCO_HIGH, 1'b1, multCode[i % 6], divCode[divChain[i][15:12]],
                 4'hF, divCode[divChain[i][11:8]], divCode[divChain[i][7:4]], 4'hF,
                 divCode[divChain[i][3:0]]};
            wr(RATIO_REG_OFFSET, d);
            rd(RATIO_REG_OFFSET, d2);
            expReg = (d & WRITABLE_MASK) | (expReg & ~WRITABLE_MASK);
            check("ratio", d2, expReg);
            expVco  = i[0];
            expMult = multRes[i % 6];
            expCpu  = divDen[divChain[i][15:12]];
            expSys  = divDen[divChain[i][11:8]];
            expExt  = divDen[divChain[i][7:4]];
            expPer  = divDen[divChain[i][3:0]];
            checkOutputs();
        end
        // prohibited codes are stored but never reach the clocks
        d = {2'h1, 1'b0, 5'h04, DIV_3, 4'h0, 4'hD, 4'hE, 4'h0, 4'hF};
        wr(RATIO_REG_OFFSET, d);
        rd(RATIO_REG_OFFSET, d2);
        expReg = (d & WRITABLE_MASK) | (expReg & ~WRITABLE_MASK);
        check("stored", d2, expReg);
        checkOutputs();
        rd(STATUS_REG_OFFSET, d2);
        check("bad codes", d2[7:0], 8'hFD);
        // status is read-only, unmapped places read zero
        wr(STATUS_REG_OFFSET, 32'h0000_0000);
        wr(8'h08, 32'h0000_0000);
        rd(8'h08, d2);
        check("unmapped", d2, 32'h0000_0000);
        rd(RATIO_REG_OFFSET, d2);
        check("untouched", d2, expReg);
        // a fifth power-on reset mid-run brings the image back
        doReset(MODE_NO_PLL);
        rd(RATIO_REG_OFFSET, d2);
        check("reinit", d2, RATIO_IMAGE_NOPLL);
        checkOutputs();
        final_report();
    end
endmodule : clock_ratio_control_test
